// >>> hw/mrita_pkg.sv
// ****************************************************************
// Shared constants and types
// ****************************************************************
package mrita_pkg;
  // Register map (word offsets as byte addresses)
  localparam logic [7:0] OFS_FUNC    = 8'h00;
  localparam logic [7:0] OFS_TOTCFG  = 8'h04;
  localparam logic [7:0] OFS_SCALE   = 8'h08;
  localparam logic [7:0] OFS_CUTOUT  = 8'h0c;
  localparam logic [7:0] OFS_ALCFG   = 8'h10;
  localparam logic [7:0] OFS_AL1     = 8'h14;
  localparam logic [7:0] OFS_AL2     = 8'h18;
  localparam logic [7:0] OFS_INPUT   = 8'h1c;
  localparam logic [7:0] OFS_TOTAL   = 8'h20;
  localparam logic [7:0] OFS_SHOWIN  = 8'h24;
  localparam logic [7:0] OFS_SHOWTOT = 8'h28;
  localparam logic [7:0] OFS_PEAK    = 8'h2c;
  localparam logic [7:0] OFS_VALLEY  = 8'h30;
  localparam logic [7:0] OFS_TARE    = 8'h34;
  localparam logic [7:0] OFS_STATUS  = 8'h38;
  // Function codes
  localparam logic [3:0] FN_TARE    = 4'h0;
  localparam logic [3:0] FN_TRST    = 4'h1;
  localparam logic [3:0] FN_TRSTEN  = 4'h2;
  localparam logic [3:0] FN_TEN     = 4'h3;
  localparam logic [3:0] FN_HOLD    = 4'h4;
  localparam logic [3:0] FN_PVRST   = 4'h5;
  localparam logic [3:0] FN_PEAK    = 4'h6;
  localparam logic [3:0] FN_VALLEY  = 4'h7;
  localparam logic [3:0] FN_ALRST   = 4'h8;
  localparam logic [3:0] FN_ALOVR   = 4'h9;
  localparam logic [3:0] FN_TOGGLE  = 4'ha;
  localparam logic [3:0] FN_ADDTARE = 4'hb;
  localparam logic [3:0] FN_HOLDTAR = 4'hc;
  localparam logic [3:0] FN_SYNC    = 4'hd;
  localparam logic [3:0] FN_PRINT   = 4'he;
  // Value limits
  localparam logic signed [31:0] TOT_MAX = 32'sd999999;
  localparam logic signed [31:0] TOT_MIN = -32'sd99999;
  localparam logic signed [31:0] TOT_SPAN = 32'sd1100000;
  localparam logic signed [31:0] SCALE_ONE = 32'sd1000;
  localparam logic [31:0] TB_DIV_SEC = 32'd1;
  localparam logic [31:0] TB_DIV_MIN = 32'd60;
  localparam logic [31:0] TB_DIV_HR  = 32'd3600;
  localparam logic [31:0] UPD_PER_SEC_X2 = 32'd5;
  // Timing
  localparam int CLK_MHZ     = 100;
  localparam int QUAL_MS     = 20;
  localparam int QUAL_CYC    = QUAL_MS * 1000 * CLK_MHZ;
  localparam int UPD_MS      = 400;
  localparam int UPD_CYC     = UPD_MS * 1000 * CLK_MHZ;
  localparam int FLASH_S     = 5;
  localparam int FLASH_CYC   = FLASH_S * 1000 * 1000 * CLK_MHZ;
  localparam int REPRINT_MS  = 800;
  localparam int REPRINT_CYC = REPRINT_MS * 1000 * CLK_MHZ;
  // Per-input event bundle
  typedef struct packed {
    logic low;
    logic fall;
    logic rise;
  } mrita_evt_t;
  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mrita_apb_t;
endpackage

// >>> hw/mrita_top.sv
`timescale 1ns/1ps
module mrita_top
  import mrita_pkg::*;
#(
  parameter int QUAL_CYCLES    = mrita_pkg::QUAL_CYC,
  parameter int UPD_CYCLES     = mrita_pkg::UPD_CYC,
  parameter int FLASH_CYCLES   = mrita_pkg::FLASH_CYC,
  parameter int REPRINT_CYCLES = mrita_pkg::REPRINT_CYC
) (
  // Clock, reset, enable
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               clkEn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Pins and measurement
  input  wire logic               remoteInputFirstN,
  input  wire logic               remoteInputSecondN,
  input  wire logic               panelLockoutPinN,
  input  wire logic signed [31:0] liveInput,
  input  wire logic               panelAl2Wr,
  input  wire logic signed [31:0] panelAl2Val,
  // Outputs
  output logic                    firstAlarmOut,
  output logic                    firstAlarmMessage,
  output logic                    printReq,
  output logic                    convRestart
);
  import mrita_pkg::*;

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  logic [1:0] s1_r, s2_r, q_r, q_nxt;
  logic [1:0] qualDone;
  logic [31:0] qcnt_r [2];
  logic [31:0] qcnt_nxt [2];
  mrita_evt_t  ev [2];

  // Two-flop synchronisers and counter qualification
  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < 2; i++) begin
      qcnt_nxt[i] = 32'h0;
      qualDone[i] = 1'b0;
      if (~s2_r[i] != q_r[i]) begin
        qcnt_nxt[i] = qcnt_r[i] + 32'h1;
        if (qcnt_r[i] >= 32'(QUAL_CYCLES - 1)) begin
          q_nxt[i]    = ~s2_r[i];
          qcnt_nxt[i] = 32'h0;
          qualDone[i] = 1'b1;
        end
      end
      ev[i].low  = q_r[i];
      ev[i].fall = qualDone[i] & ~q_r[i];
      ev[i].rise = qualDone[i] & q_r[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_r <= 2'h3;
      s2_r <= 2'h3;
      q_r  <= 2'h0;
      qcnt_r[0] <= 32'h0;
      qcnt_r[1] <= 32'h0;
    end else if (clkEn) begin
      s1_r <= {remoteInputSecondN, remoteInputFirstN};
      s2_r <= s1_r;
      q_r  <= q_nxt;
      qcnt_r[0] <= qcnt_nxt[0];
      qcnt_r[1] <= qcnt_nxt[1];
    end
  end

  // Lockout pin synchroniser
  logic lk1_r, lk2_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lk1_r <= 1'b1;
      lk2_r <= 1'b1;
    end else if (clkEn) begin
      lk1_r <= panelLockoutPinN;
      lk2_r <= lk1_r;
    end
  end

  // ****************************************************************
  // Configuration and state
  // ****************************************************************
  logic [7:0]         func_r, func_nxt;
  logic [1:0]         tb_r, tb_nxt;
  logic signed [31:0] scale_r, scale_nxt, cut_r, cut_nxt;
  logic [2:0]         alcfg_r, alcfg_nxt;  // 0 latch, 1 total, 2 track
  logic [1:0]         alflg_r, alflg_nxt;  // 0 high acting, 1 msg enable
  logic signed [31:0] al1_r, al1_nxt, al2_r, al2_nxt;
  logic signed [31:0] tare_r, tare_nxt, tot_r, tot_nxt;
  logic signed [31:0] peak_r, peak_nxt, vall_r, vall_nxt;
  logic signed [31:0] hIn_r, hIn_nxt, hTot_r, hTot_nxt;
  logic               ovf_r, ovf_nxt, accEn_r, accEn_nxt, showTot_r, showTot_nxt;
  logic               hold_r, hold_nxt, latch_r, latch_nxt;
  logic [31:0]        upd_r, upd_nxt, fl_r, fl_nxt, pr_r, pr_nxt;
  logic [31:0]        frac_r, frac_nxt;
  logic               prReq_nxt, cvRs_nxt, msg_nxt, alOut_nxt;

  logic signed [31:0] netIn, cmpVal, incr, sum;
  logic [31:0]        tbDiv;
  logic               suspend, override, alCond, wrEn, stopAcc;
  logic [3:0]         code [2];
  logic signed [63:0] prod;

  assign wrEn    = psel & penable & pwrite;
  assign code[0] = func_r[3:0];
  assign code[1] = func_r[7:4];
  assign netIn   = liveInput - tare_r;

  // Main behaviour; input one handled after input two so it has last word
  always_comb begin
    func_nxt = func_r;   tb_nxt = tb_r;     scale_nxt = scale_r; cut_nxt = cut_r;
    alcfg_nxt = alcfg_r; alflg_nxt = alflg_r;
    al1_nxt = al1_r;     al2_nxt = al2_r;   tare_nxt = tare_r;   tot_nxt = tot_r;
    peak_nxt = peak_r;   vall_nxt = vall_r; hIn_nxt = hIn_r;     hTot_nxt = hTot_r;
    ovf_nxt = ovf_r;     accEn_nxt = accEn_r; showTot_nxt = showTot_r;
    hold_nxt = 1'b0;     latch_nxt = latch_r; upd_nxt = upd_r + 32'h1;
    fl_nxt = fl_r;       pr_nxt = pr_r;     frac_nxt = frac_r;
    prReq_nxt = 1'b0;    cvRs_nxt = 1'b0;   suspend = 1'b0;      override = 1'b0;
    stopAcc = 1'b0;
    incr = 32'sh0;       sum = tot_r;       prod = 64'sh0;
    // Level functions
    for (int i = 0; i < 2; i++) begin
      if (code[i] == FN_SYNC && ev[i].low) suspend = 1'b1;
      if (code[i] == FN_ALOVR && ev[i].low) override = 1'b1;
      // Enable-type codes only let the total run while their pin is low
      if ((code[i] == FN_TRSTEN || code[i] == FN_TEN) && !ev[i].low)
        stopAcc = 1'b1;
      if ((code[i] == FN_HOLD || code[i] == FN_HOLDTAR) && ev[i].low)
        hold_nxt = 1'b1;
    end
    // Peak and valley tracking
    if (netIn > peak_r) peak_nxt = netIn;
    if (netIn < vall_r) vall_nxt = netIn;
    for (int i = 0; i < 2; i++) begin
      if (code[i] == FN_PEAK && !ev[i].low) peak_nxt = peak_r;
      if (code[i] == FN_VALLEY && !ev[i].low) vall_nxt = vall_r;
    end
    // Accumulation at fixed update rate
    case (tb_r)
      2'h1:    tbDiv = TB_DIV_MIN;
      2'h2:    tbDiv = TB_DIV_HR;
      default: tbDiv = TB_DIV_SEC;
    endcase
    if (upd_r >= 32'(UPD_CYCLES - 1)) begin
      upd_nxt = 32'h0;
      if (accEn_r && !suspend && !stopAcc && netIn >= cut_r &&
          code[0] != FN_ADDTARE && code[1] != FN_ADDTARE) begin
        prod = 64'(netIn) * 64'(scale_r) * 64'sd2;
        incr = 32'(prod / (64'(SCALE_ONE) * 64'(UPD_PER_SEC_X2) * 64'(tbDiv)));
        sum  = tot_r + incr;
      end
    end
    // Edge functions, second input first so the first takes precedence
    for (int j = 1; j >= 0; j--) begin
      if (ev[j].fall) begin
        case (code[j])
          FN_TARE:    tare_nxt = liveInput;
          FN_TRST:    begin sum = 32'sh0; accEn_nxt = 1'b1; ovf_nxt = 1'b0; end
          FN_TRSTEN:  begin sum = 32'sh0; accEn_nxt = 1'b1; ovf_nxt = 1'b0; end
          FN_TEN:     accEn_nxt = 1'b1;
          FN_PVRST:   begin peak_nxt = netIn; vall_nxt = netIn; end
          FN_PEAK:    peak_nxt = netIn;
          FN_VALLEY:  vall_nxt = netIn;
          FN_ALRST:   latch_nxt = 1'b0;
          FN_TOGGLE:  showTot_nxt = ~showTot_r;
          FN_ADDTARE: begin sum = sum + netIn; tare_nxt = liveInput; end
          FN_HOLDTAR: begin hIn_nxt = netIn; tare_nxt = liveInput; end
          FN_PRINT:   begin prReq_nxt = 1'b1; pr_nxt = 32'h0; end
          default:    ;
        endcase
      end
      if (ev[j].rise) begin
        if (code[j] == FN_TRSTEN || code[j] == FN_TEN) accEn_nxt = 1'b0;
        if (code[j] == FN_SYNC) cvRs_nxt = 1'b1;
      end
      if (code[j] == FN_PRINT && ev[j].low && !ev[j].fall) begin
        pr_nxt = pr_r + 32'h1;
        if (pr_r >= 32'(REPRINT_CYCLES - 1)) begin
          prReq_nxt = 1'b1;
          pr_nxt    = 32'h0;
        end
      end
    end
    // Rollover with overflow flag
    if (sum > TOT_MAX) begin
      tot_nxt = sum - TOT_SPAN;
      ovf_nxt = ~ovf_r;
    end else if (sum < TOT_MIN) begin
      tot_nxt = sum + TOT_SPAN;
      ovf_nxt = ~ovf_r;
    end else begin
      tot_nxt = sum;
    end
    if (suspend) tot_nxt = tot_r;
    // Display hold capture
    if (!hold_r) begin
      if (!(ev[0].fall && code[0] == FN_HOLDTAR) && !(ev[1].fall && code[1] == FN_HOLDTAR))
        hIn_nxt = netIn;
      hTot_nxt = tot_r;
    end
    // First alarm
    cmpVal = alcfg_r[1] ? tot_r : netIn;
    alCond = alflg_r[0] ? (cmpVal >= al1_r) : (cmpVal <= al1_r);
    if (alCond && alcfg_r[0] && !suspend) latch_nxt = 1'b1;
    if (override) latch_nxt = 1'b0;
    alOut_nxt = !override && !suspend && (alcfg_r[0] ? latch_nxt : alCond);
    // Message flashing
    fl_nxt = alOut_nxt ? fl_r + 32'h1 : 32'h0;
    if (fl_r >= 32'(FLASH_CYCLES - 1)) fl_nxt = 32'h0;
    msg_nxt = alOut_nxt && alflg_r[1] && (fl_r < 32'(UPD_CYCLES));
    // Register writes
    if (wrEn) begin
      if (paddr == OFS_FUNC) func_nxt = pwdata[7:0];
      else if (paddr == OFS_TOTCFG) tb_nxt = pwdata[1:0];
      else if (paddr == OFS_SCALE) scale_nxt = pwdata;
      else if (paddr == OFS_CUTOUT) cut_nxt = pwdata;
      else if (paddr == OFS_ALCFG) begin
        alcfg_nxt = pwdata[2:0];
        alflg_nxt = pwdata[4:3];
      end else if (paddr == OFS_AL1) al1_nxt = pwdata;
      else if (paddr == OFS_AL2) begin
        al2_nxt = pwdata;
        if (alcfg_r[2]) al1_nxt = al1_r + (pwdata - al2_r);
      end else if (paddr == OFS_TARE) tare_nxt = pwdata;
    end else if (panelAl2Wr) begin
      al2_nxt = panelAl2Val;
      if (alcfg_r[2] && !lk2_r) al1_nxt = al1_r + (panelAl2Val - al2_r);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      func_r <= 8'h00; tb_r <= 2'h0; scale_r <= SCALE_ONE; cut_r <= TOT_MIN;
      alcfg_r <= 3'h0; alflg_r <= 2'h1; al1_r <= 32'sh0; al2_r <= 32'sh0;
      tare_r <= 32'sh0; tot_r <= 32'sh0; peak_r <= TOT_MIN; vall_r <= TOT_MAX;
      hIn_r <= 32'sh0; hTot_r <= 32'sh0; ovf_r <= 1'b0; accEn_r <= 1'b1;
      showTot_r <= 1'b0; hold_r <= 1'b0; latch_r <= 1'b0;
      upd_r <= 32'h0; fl_r <= 32'h0; pr_r <= 32'h0; frac_r <= 32'h0;
      printReq <= 1'b0; convRestart <= 1'b0;
      firstAlarmOut <= 1'b0; firstAlarmMessage <= 1'b0;
    end else if (clkEn) begin
      func_r <= func_nxt; tb_r <= tb_nxt; scale_r <= scale_nxt; cut_r <= cut_nxt;
      alcfg_r <= alcfg_nxt; alflg_r <= alflg_nxt; al1_r <= al1_nxt; al2_r <= al2_nxt;
      tare_r <= tare_nxt; tot_r <= tot_nxt; peak_r <= peak_nxt; vall_r <= vall_nxt;
      hIn_r <= hIn_nxt; hTot_r <= hTot_nxt; ovf_r <= ovf_nxt; accEn_r <= accEn_nxt;
      showTot_r <= showTot_nxt; hold_r <= hold_nxt; latch_r <= latch_nxt;
      upd_r <= upd_nxt; fl_r <= fl_nxt; pr_r <= pr_nxt; frac_r <= frac_nxt;
      printReq <= prReq_nxt; convRestart <= cvRs_nxt;
      firstAlarmOut <= alOut_nxt; firstAlarmMessage <= msg_nxt;
    end
  end

  // ****************************************************************
  // APB read side
  // ****************************************************************
  // Zero-wait slave; INPUT, SHOWIN and SHOWTOT reads show frozen values during hold, other reads stay live
  always_comb begin
    prdata  = 32'h0;
    pslverr = 1'b0;
    pready  = 1'b1;
    if (!(psel && penable)) prdata = 32'h0;
    else if (paddr == OFS_FUNC) prdata = {24'h0, func_r};
    else if (paddr == OFS_TOTCFG) prdata = {30'h0, tb_r};
    else if (paddr == OFS_SCALE) prdata = scale_r;
    else if (paddr == OFS_CUTOUT) prdata = cut_r;
    else if (paddr == OFS_ALCFG) prdata = {27'h0, alflg_r, alcfg_r};
    else if (paddr == OFS_AL1) prdata = al1_r;
    else if (paddr == OFS_AL2) prdata = al2_r;
    else if (paddr == OFS_INPUT) prdata = hold_r ? hIn_r : netIn;
    else if (paddr == OFS_TOTAL) prdata = tot_r;
    else if (paddr == OFS_SHOWIN) prdata = hIn_r;
    else if (paddr == OFS_SHOWTOT) prdata = hold_r ? hTot_r : tot_r;
    else if (paddr == OFS_PEAK) prdata = peak_r;
    else if (paddr == OFS_VALLEY) prdata = vall_r;
    else if (paddr == OFS_TARE) prdata = tare_r;
    else if (paddr == OFS_STATUS)
      prdata = {26'h0, q_r, latch_r, accEn_r, showTot_r, ovf_r};
    else pslverr = 1'b1;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_print_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    printReq |=> !printReq) else $error("print strobe too long");
  a_restart_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    convRestart |=> !convRestart) else $error("restart strobe too long");
  a_fall_low: assert property (@(posedge sys_clk) disable iff (rst)
    clkEn && ev[0].fall |=> q_r[0]) else $error("edge not qualified");
  a_override_off: assert property (@(posedge sys_clk) disable iff (rst)
    clkEn && override |=> !firstAlarmOut) else $error("override ignored");
  a_tare_take: assert property (@(posedge sys_clk) disable iff (rst)
    clkEn && !wrEn && ev[0].fall && code[0] == FN_TARE |=> tare_r == $past(liveInput))
    else $error("tare not captured");
  a_total_range: assert property (@(posedge sys_clk) disable iff (rst)
    tot_r <= TOT_MAX && tot_r >= TOT_MIN) else $error("total out of range");
  a_toggle_flip: assert property (@(posedge sys_clk) disable iff (rst)
    clkEn && ev[0].fall && code[0] == FN_TOGGLE && !(ev[1].fall && code[1] == FN_TOGGLE)
    |=> showTot_r != $past(showTot_r)) else $error("toggle failed");
  a_suspend_hold: assert property (@(posedge sys_clk) disable iff (rst)
    clkEn && suspend |=> tot_r == $past(tot_r)) else $error("total moved");
  c_print: cover property (@(posedge sys_clk) printReq);
  c_alarm: cover property (@(posedge sys_clk) firstAlarmOut);
  c_restart: cover property (@(posedge sys_clk) convRestart);
endmodule

// >>> dv/mrita_contact_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Contact closures on the two remote pins, with contact bounce
// ****************************************************************
module mrita_contact_model (
  // Clock
  input  wire logic       sys_clk,
  // Requested closure per pin, high closes the contact
  input  wire logic [1:0] holdLow,
  // Active-low pins toward the meter
  output logic [1:0]      pinN = 2'b11
);
  logic [1:0] prev_r = 2'b00;
  logic [2:0] bounce_r [2] = '{3'h0, 3'h0};

  // Each closure chatters for three cycles before it settles low
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 2; i++) begin
      prev_r[i] <= holdLow[i];
      if (holdLow[i] && !prev_r[i]) begin
        bounce_r[i] <= 3'h3;
      end else if (bounce_r[i] != 3'h0) begin
        bounce_r[i] <= bounce_r[i] - 3'h1;
      end
      // Closure time is chosen by the bench, the model only passes it on
      pinN[i] <= (bounce_r[i] != 3'h0) ? bounce_r[i][0] : ~holdLow[i];
    end
  end
endmodule

// >>> dv/meter_remote_input_totalizer_alarm_bench.sv
`timescale 1ns/1ps
module meter_remote_input_totalizer_alarm_bench;
  import mrita_pkg::*;
  localparam int QC = 4;
  localparam int UC = 8;
  localparam int FC = 64;
  localparam int RC = 16;
  logic               sys_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, lockN = 1'b1;
  logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0, al2Wr = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata;
  logic signed [31:0] liveIn = 32'sh0, al2Val = 32'sh0;
  logic               pready, pslverr, alarmOut, alarmMsg, printReq, convRestart;
  logic               prPrev = 1'b0, crPrev = 1'b0;
  logic [1:0]         holdLow = 2'b00, pinN;
  int                 mismatches = 0, n_checks = 0, prCnt = 0, crCnt = 0, wide = 0;

  // ****************************************************************
  // Clock, design, contacts, strobe monitor
  // ****************************************************************
  always #5 sys_clk = ~sys_clk;
  mrita_top #(.QUAL_CYCLES(QC), .UPD_CYCLES(UC), .FLASH_CYCLES(FC), .REPRINT_CYCLES(RC)) DUT (
    .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .remoteInputFirstN(pinN[0]), .remoteInputSecondN(pinN[1]),
    .panelLockoutPinN(lockN), .liveInput(liveIn), .panelAl2Wr(al2Wr),
    .panelAl2Val(al2Val), .firstAlarmOut(alarmOut), .firstAlarmMessage(alarmMsg),
    .printReq(printReq), .convRestart(convRestart));
  mrita_contact_model CONTACTS (.sys_clk(sys_clk), .holdLow(holdLow), .pinN(pinN));
  // Counts strobes and any strobe longer than one cycle
  always @(posedge sys_clk) begin
    if (printReq === 1'b1) prCnt++;
    if (convRestart === 1'b1) crCnt++;
    if ((printReq === 1'b1 && prPrev) || (convRestart === 1'b1 && crPrev)) wide++;
    prPrev = (printReq === 1'b1);
    crPrev = (convRestart === 1'b1);
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tally_and_finish;
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic b, input logic e);
    chk({31'h0, b}, {31'h0, e});
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) mismatches++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask
  task automatic stbit(input int n, input logic e);
    logic [31:0] q;
    logic x;
    apb(1'b0, OFS_STATUS, 32'h0, q, x);
    chkb(q[n], e);
  endtask
  // Closes contact i for n cycles, then lets qualification settle
  task automatic press(input int i, input int n);
    holdLow[i] <= 1'b1;
    pause(n);
    holdLow[i] <= 1'b0;
    pause(12);
  endtask
  // Total growth over a span must be a positive multiple of step, or zero for step 0
  task automatic rate(input int step);
    logic [31:0] q1, q2;
    logic e;
    int d;
    apb(1'b0, OFS_TOTAL, 32'h0, q1, e);
    pause(80);
    apb(1'b0, OFS_TOTAL, 32'h0, q2, e);
    d = $signed(q2) - $signed(q1);
    chkb(step == 0 ? d == 0 : (d > 0 && d % step == 0), 1'b1);
  endtask
  task automatic msgWin(input int exp);
    int c;
    c = 0;
    repeat (FC) begin
      @(posedge sys_clk);
      if (alarmMsg === 1'b1) c++;
    end
    chk(c, exp);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rdchk(OFS_SCALE, 32'h3e8);
    rdchk(OFS_CUTOUT, 32'hfffe7961);
    rdchk(OFS_TOTAL, 32'h0);
    apb(1'b0, 8'h3c, 32'h0, q, e);
    chkb(e, 1'b1);
  endtask
  task automatic t_addtare;
    wr(OFS_FUNC, 32'h0b);
    liveIn <= 32'sd300;
    press(0, 2);
    rdchk(OFS_TOTAL, 32'h0);
    press(0, 14);
    rdchk(OFS_TOTAL, 32'h12c);
    rdchk(OFS_INPUT, 32'h0);
    liveIn <= 32'sd1000299;
    press(0, 14);
    rdchk(OFS_TOTAL, 32'hfffe7a8b);
    stbit(0, 1'b1);
    wr(OFS_FUNC, 32'h00);
    liveIn <= 32'sd1000;
    press(0, 14);
    rdchk(OFS_TARE, 32'h3e8);
    rdchk(OFS_INPUT, 32'h0);
  endtask
  task automatic t_total;
    wr(OFS_FUNC, 32'h03);
    liveIn <= 32'sd1500;
    rate(0);
    holdLow[0] <= 1'b1;
    rate(200);
    holdLow[0] <= 1'b0;
    pause(12);
    rate(0);
    wr(OFS_FUNC, 32'h01);
    press(0, 14);
    rate(200);
    wr(OFS_CUTOUT, 32'd600);
    rate(0);
    wr(OFS_CUTOUT, 32'h0);
    wr(OFS_SCALE, 32'd2000);
    rate(400);
    wr(OFS_TOTCFG, 32'h1);
    rate(6);
    wr(OFS_TOTCFG, 32'h2);
    rate(0);
  endtask
  task automatic t_display;
    wr(OFS_FUNC, 32'h0a);
    press(0, 14);
    stbit(1, 1'b1);
    press(0, 14);
    stbit(1, 1'b0);
    wr(OFS_FUNC, 32'h04);
    liveIn <= 32'sd1200;
    holdLow[0] <= 1'b1;
    pause(12);
    liveIn <= 32'sd1250;
    pause(3);
    rdchk(OFS_INPUT, 32'd200);
    holdLow[0] <= 1'b0;
    pause(12);
    wr(OFS_FUNC, 32'h06);
    liveIn <= 32'sd1200;
    holdLow[0] <= 1'b1;
    pause(12);
    liveIn <= 32'sd1300;
    pause(3);
    liveIn <= 32'sd1100;
    pause(3);
    holdLow[0] <= 1'b0;
    pause(12);
    liveIn <= 32'sd1400;
    pause(3);
    rdchk(OFS_PEAK, 32'd300);
  endtask
  task automatic t_strobes;
    int p, c;
    wr(OFS_FUNC, 32'hed);
    p = prCnt;
    c = crCnt;
    press(1, 14);
    chk(prCnt - p, 1);
    press(0, 14);
    chk(crCnt - c, 1);
    holdLow <= 2'b11;
    pause(14);
    holdLow <= 2'b00;
    pause(12);
    chk(prCnt - p + crCnt - c, 4);
    chk(wide, 0);
  endtask
  task automatic t_alarm;
    wr(OFS_AL1, 32'd100);
    wr(OFS_ALCFG, 32'h19);
    liveIn <= 32'sd1200;
    pause(4);
    chkb(alarmOut, 1'b1);
    msgWin(UC);
    liveIn <= 32'sd1000;
    pause(4);
    chkb(alarmOut, 1'b1);
    wr(OFS_FUNC, 32'h08);
    press(0, 14);
    chkb(alarmOut, 1'b0);
    msgWin(0);
    wr(OFS_ALCFG, 32'h08);
    wr(OFS_FUNC, 32'h09);
    liveIn <= 32'sd1200;
    pause(4);
    chkb(alarmOut, 1'b1);
    holdLow[0] <= 1'b1;
    pause(14);
    chkb(alarmOut, 1'b0);
    holdLow[0] <= 1'b0;
    pause(12);
    chkb(alarmOut, 1'b1);
    wr(OFS_ALCFG, 32'h0c);
    wr(OFS_AL2, 32'd500);
    wr(OFS_AL1, 32'd100);
    wr(OFS_AL2, 32'd550);
    rdchk(OFS_AL1, 32'd150);
    al2Val <= 32'sd600;
    al2Wr <= 1'b1;
    pause(1);
    al2Wr <= 1'b0;
    rdchk(OFS_AL1, 32'd150);
    lockN <= 1'b0;
    al2Val <= 32'sd650;
    pause(4);
    al2Wr <= 1'b1;
    pause(1);
    al2Wr <= 1'b0;
    rdchk(OFS_AL1, 32'd200);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    pause(8);
    rst <= 1'b0;
    t_reset();
    t_addtare();
    t_total();
    t_display();
    t_strobes();
    t_alarm();
    tally_and_finish();
  end
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule
